/* design/tsw_slave.sv */
module tsw_slave
    import tsw_pkg::*;
#(
    parameter int unsigned DEV_VERSION = 0,
    parameter int unsigned TMO_CYCLES = TIMEOUT_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] rd_data_i,
    output logic [7:0] ptr_o,
    output tsw_wr_t wr_o,
    output logic wr_valid_o,
    output logic gc_reset_o,
    output logic hs_mode_o,
    output logic busy_o,
    output logic timeout_o,
    output logic sda_o,
    output logic sda_oe_o
);

    localparam int unsigned TMO_W = $clog2(TMO_CYCLES + 1);
    localparam logic [6:0] OWN_ADDR = 7'(ADDR_BASE + DEV_VERSION);
    localparam logic [3:0] OWN_SLOT = 4'(DEV_VERSION);

    // refuse settings the logic cannot serve
    if (DEV_VERSION >= NUM_SLOTS) begin : g_bad_version
        $error("version index must be below eight");
    end
    if (TMO_CYCLES < 2) begin : g_bad_timeout
        $error("timeout must be at least two cycles");
    end

    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] line_f;
    logic [2:0] filt_cnt [2];
    logic [2:0] filt_lim;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [TMO_W-1:0] tmo_cnt;
    logic tmo_hit;
    tsw_state_t state;
    tsw_phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic to_tx;
    logic tx_mine;
    logic bc_rd;
    logic [3:0] slot;
    logic hs;
    logic ack_byte;
    logic skip_byte;
    logic [7:0] rx_byte;

    // two-stage synchronisers for both bus lines
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pin_meta <= 2'h3;
            pin_sync <= 2'h3;
        end else begin
            pin_meta <= {sda_i, scl_i};
            pin_sync <= pin_meta;
        end
    end

    // spike filter length follows the bus speed mode
    assign filt_lim = hs ? HS_FILT_CYC : FM_FILT_CYC;

    // a line changes only after staying stable for the filter length
    for (genvar i = 0; i < 2; i++) begin : g_filt
        always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
                line_f[i] <= 1'b1;
                filt_cnt[i] <= 3'h0;
            end else if (pin_sync[i] == line_f[i]) begin
                filt_cnt[i] <= 3'h0;
            end else if (filt_cnt[i] >= filt_lim - 3'h1) begin
                line_f[i] <= pin_sync[i];
                filt_cnt[i] <= 3'h0;
            end else begin
                filt_cnt[i] <= filt_cnt[i] + 3'h1;
            end
        end
    end

    // previous filtered levels for edge finding
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= line_f[LINE_SCL];
            sda_q <= line_f[LINE_SDA];
        end
    end

    // clock edges and start or stop conditions
    assign scl_rise = line_f[LINE_SCL] & ~scl_q;
    assign scl_fall = ~line_f[LINE_SCL] & scl_q;
    assign start_det = scl_q & line_f[LINE_SCL]
                       & sda_q & ~line_f[LINE_SDA];
    assign stop_det = scl_q & line_f[LINE_SCL]
                      & ~sda_q & line_f[LINE_SDA];

    // count cycles with SCL low, saturating at the limit
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || line_f[LINE_SCL]) begin
            tmo_cnt <= '0;
        end else if (tmo_cnt != TMO_W'(TMO_CYCLES)) begin
            tmo_cnt <= tmo_cnt + TMO_W'(1);
        end
    end

    // one pulse when SCL has been low for the whole timeout
    assign tmo_hit = ~line_f[LINE_SCL]
                     & (tmo_cnt == TMO_W'(TMO_CYCLES - 1));

    // the completed byte as the master sent it, msb first
    assign rx_byte = shift;

    // decide whether the completed byte is acknowledged
    always_comb begin
        ack_byte = 1'b0;
        skip_byte = 1'b0;
        case (phase)
            PH_ADDR: begin
                if (rx_byte[7:1] == OWN_ADDR) begin
                    ack_byte = 1'b1;
                end else if (rx_byte == BC_WR_BYTE
                             || rx_byte == BC_RD_BYTE) begin
                    ack_byte = 1'b1;
                end else begin
                    skip_byte = 1'b1;
                end
            end
            PH_BCPTR: begin
                if (rx_byte != GC_RESET_CMD && rx_byte[0]) begin
                    skip_byte = 1'b1;
                end else begin
                    ack_byte = 1'b1;
                end
            end
            PH_PTR, PH_DATA: begin
                ack_byte = 1'b1;
            end
            default: begin
                skip_byte = 1'b1;
            end
        endcase
    end

    // high-speed filters from master code until the stop
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || stop_det) begin
            hs <= 1'b0;
        end else if (state == ST_RX && scl_fall && bit_cnt == BITS_PER_BYTE
                     && phase == PH_ADDR && rx_byte[7:3] == HS_CODE_TOP) begin
            hs <= 1'b1;
        end
    end

    // protocol engine: shifting, acknowledge and transmit
    always_ff @(posedge ref_clk_i) begin
        wr_valid_o <= 1'b0;
        gc_reset_o <= 1'b0;
        if (rst_i) begin
            state <= ST_IDLE;
            phase <= PH_ADDR;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            to_tx <= 1'b0;
            tx_mine <= 1'b0;
            bc_rd <= 1'b0;
            slot <= 4'h0;
            sda_oe_o <= 1'b0;
            ptr_o <= PTR_RST;
            wr_o <= '0;
        end else if (tmo_hit) begin
            state <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end else if (start_det) begin
            state <= ST_RX;
            phase <= PH_ADDR;
            bit_cnt <= 4'h0;
            sda_oe_o <= 1'b0;
        end else begin
            case (state)
                ST_RX: begin
                    if (scl_rise && bit_cnt != BITS_PER_BYTE) begin
                        shift <= {shift[6:0], line_f[LINE_SDA]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                        if (skip_byte) begin
                            state <= ST_SKIP;
                        end else if (ack_byte) begin
                            sda_oe_o <= 1'b1;
                            state <= ST_ACK;
                        end
                        case (phase)
                            PH_ADDR: begin
                                to_tx <= rx_byte[0];
                                bc_rd <= (rx_byte == BC_RD_BYTE);
                                slot <= 4'h0;
                                if (rx_byte == BC_RD_BYTE) begin
                                    tx_mine <= (OWN_SLOT == 4'h0);
                                end else begin
                                    tx_mine <= 1'b1;
                                end
                                if (rx_byte == BC_WR_BYTE) begin
                                    phase <= PH_BCPTR;
                                end else begin
                                    phase <= PH_PTR;
                                end
                            end
                            PH_BCPTR: begin
                                if (rx_byte == GC_RESET_CMD) begin
                                    gc_reset_o <= 1'b1;
                                    ptr_o <= PTR_RST;
                                    phase <= PH_DONE;
                                end else if (!rx_byte[0]) begin
                                    ptr_o <= rx_byte;
                                    phase <= PH_DATA;
                                end
                            end
                            PH_PTR: begin
                                ptr_o <= rx_byte;
                                phase <= PH_DATA;
                            end
                            PH_DATA: begin
                                wr_o.ptr <= ptr_o;
                                wr_o.data <= rx_byte;
                                wr_valid_o <= 1'b1;
                            end
                            default: begin
                                phase <= PH_DONE;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (to_tx) begin
                            shift <= rd_data_i;
                            sda_oe_o <= tx_mine & ~rd_data_i[7];
                            state <= ST_TX;
                        end else if (phase == PH_DONE) begin
                            sda_oe_o <= 1'b0;
                            state <= ST_SKIP;
                        end else begin
                            sda_oe_o <= 1'b0;
                            state <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == BITS_PER_BYTE) begin
                            sda_oe_o <= 1'b0;
                            state <= ST_MACK;
                        end else begin
                            shift <= {shift[6:0], 1'b0};
                            sda_oe_o <= tx_mine & ~shift[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        if (line_f[LINE_SDA]) begin
                            state <= ST_SKIP;
                        end else begin
                            state <= ST_ACK;
                            if (bc_rd) begin
                                if (slot != 4'hF) begin
                                    slot <= slot + 4'h1;
                                end
                                tx_mine <= (slot + 4'h1 == OWN_SLOT);
                            end
                        end
                    end
                end
                ST_SKIP: begin
                    sda_oe_o <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // status outputs and the constant low level of the open drain
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hs_mode_o <= 1'b0;
            busy_o <= 1'b0;
            timeout_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            hs_mode_o <= hs;
            busy_o <= (state != ST_IDLE);
            timeout_o <= tmo_hit;
            sda_o <= 1'b0;
        end
    end

endmodule

/* design/tsw_pkg.sv */
package tsw_pkg;

    // clock rate and timing figures
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TIMEOUT_MS = 30;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned FM_FILT_NS = 100;
    localparam int unsigned HS_FILT_NS = 10;
    localparam int unsigned FM_FILT_RAW = (FM_FILT_NS * (CLK_HZ / 1_000_000)
                                           + 999) / 1000;
    localparam int unsigned HS_FILT_RAW = (HS_FILT_NS * (CLK_HZ / 1_000_000)
                                           + 999) / 1000;
    localparam logic [2:0] FM_FILT_CYC = 3'(FM_FILT_RAW < 1 ? 1 : FM_FILT_RAW);
    localparam logic [2:0] HS_FILT_CYC = 3'(HS_FILT_RAW < 1 ? 1 : HS_FILT_RAW);

    // address and command codes
    localparam logic [6:0] ADDR_BASE = 7'h70;
    localparam int unsigned NUM_SLOTS = 8;
    localparam logic [7:0] BC_WR_BYTE = 8'h00;
    localparam logic [7:0] BC_RD_BYTE = 8'h01;
    localparam logic [7:0] GC_RESET_CMD = 8'h06;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;

    // reset values and byte layout
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int unsigned LINE_SCL = 0;
    localparam int unsigned LINE_SDA = 1;

    // protocol states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100,
        ST_SKIP = 3'b101
    } tsw_state_t;

    // meaning of the byte being received
    typedef enum logic [2:0] {
        PH_ADDR = 3'b000,
        PH_PTR = 3'b001,
        PH_BCPTR = 3'b010,
        PH_DATA = 3'b011,
        PH_DONE = 3'b100
    } tsw_phase_t;

    // register write handed to the register file
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
    } tsw_wr_t;

endpackage

/* verification/tsw_slave_properties.sv */
module tsw_slave_properties
    import tsw_pkg::*;
#(
    parameter int unsigned TMO_CYCLES = TIMEOUT_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] rd_data_i,
    input wire logic [7:0] ptr_o,
    input wire tsw_wr_t wr_o,
    input wire logic wr_valid_o,
    input wire logic gc_reset_o,
    input wire logic hs_mode_o,
    input wire logic busy_o,
    input wire logic timeout_o,
    input wire logic sda_o,
    input wire logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    int unsigned low_cnt;
    // length of the current SCL low stretch at the pin
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || scl_i)
            low_cnt <= 0;
        else
            low_cnt <= low_cnt + 1;
    end
    // steps, each used by one property only
    sequence s_no_ack8;
        !sda_oe_o [*8];
    endsequence
    sequence s_no_wr8;
        !wr_valid_o [*8];
    endsequence
    AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
        else $error("sda output level not low");
    AST_SDA_SCL_LOW: assert property (
        $changed(sda_oe_o) |-> !$past(scl_i))
        else $error("sda drive changed while scl high");
    AST_WR_ACK: assert property (wr_valid_o |-> sda_oe_o)
        else $error("data byte written without ack");
    AST_WR_ONCE: assert property (wr_valid_o |=> s_no_wr8)
        else $error("write pulse repeated within a byte");
    AST_WR_PTR: assert property (wr_valid_o |-> wr_o.ptr == ptr_o)
        else $error("write target differs from pointer");
    AST_GC_PTR: assert property (gc_reset_o |-> ptr_o == PTR_RST)
        else $error("pointer not cleared by general reset");
    AST_HS_NOACK: assert property ($rose(hs_mode_o) |-> s_no_ack8)
        else $error("master code acknowledged");
    AST_HS_STOP: assert property ($fell(hs_mode_o) |-> scl_i && sda_i)
        else $error("high speed left without stop");
    AST_TMO_CNT: assert property (timeout_o |->
        low_cnt >= TMO_CYCLES && low_cnt <= TMO_CYCLES + 10)
        else $error("timeout fired at wrong low length");
    AST_TMO_IDLE: assert property (timeout_o |=>
        (!sda_oe_o && !busy_o) [*4])
        else $error("bus not released after timeout");
    AST_IDLE_QUIET: assert property (!busy_o && !$past(busy_o) |->
        !sda_oe_o)
        else $error("sda driven while idle");
endmodule

bind tsw_slave tsw_slave_properties #(.TMO_CYCLES(TMO_CYCLES)) u_props (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
    .rd_data_i(rd_data_i), .ptr_o(ptr_o), .wr_o(wr_o),
    .wr_valid_o(wr_valid_o), .gc_reset_o(gc_reset_o),
    .hs_mode_o(hs_mode_o), .busy_o(busy_o), .timeout_o(timeout_o),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o)
);

/* verification/tsw_master.sv */
module tsw_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // bus idle: both lines released
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one bit of 8 cycles, data moved only while scl low
    task automatic bt(input logic b, output logic r);
        tk(3);
        sda_oe_o <= ~b;
        tk(2);
        scl_o <= 1'b1;
        tk(2);
        r = sda_i;
        tk(1);
        scl_o <= 1'b0;
    endtask
    // start or repeated start, also before the hs address
    task automatic st();
        tk(3);
        sda_oe_o <= 1'b0;
        tk(2);
        scl_o <= 1'b1;
        tk(3);
        sda_oe_o <= 1'b1;
        tk(3);
        scl_o <= 1'b0;
    endtask
    // stop, then scl stands high
    task automatic sp();
        tk(3);
        sda_oe_o <= 1'b1;
        tk(2);
        scl_o <= 1'b1;
        tk(3);
        sda_oe_o <= 1'b0;
        tk(8);
    endtask
    // byte msb first, then ack bit driven low when a is 0
    task automatic xb(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bt(d[i], r);
            q[i] = r;
        end
        bt(a, k);
    endtask
endmodule

/* verification/tb.sv */
module tb;
    import tsw_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int V = 2;
    localparam int TMO = 200;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic scl, m_oe, sda, wr_valid, gc_reset, hs_mode, busy, tmo, s_o, s_oe;
    logic [7:0] rd_data = 8'h00;
    logic [7:0] ptr;
    tsw_wr_t wr, last_wr;
    int mismatches = 0;
    int n_tests = 0;
    int n_wr = 0;
    int n_gc = 0;
    int n_tmo = 0;
    logic [31:0] rng = 32'h000114D0;
    always #25 ref_clk = ~ref_clk;
    // open-drain wire with pull-up
    assign sda = m_oe ? 1'b0 : (s_oe ? s_o : 1'b1);
    tsw_master m (.clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    tsw_slave #(.DEV_VERSION(V), .TMO_CYCLES(TMO)) dut (
        .ref_clk_i(ref_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
        .rd_data_i(rd_data), .ptr_o(ptr), .wr_o(wr), .wr_valid_o(wr_valid),
        .gc_reset_o(gc_reset), .hs_mode_o(hs_mode), .busy_o(busy),
        .timeout_o(tmo), .sda_o(s_o), .sda_oe_o(s_oe));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [7:0] rfn(input logic [7:0] v);
        return v ^ 8'hA5;
    endfunction
    // register file stand-in and pulse monitors
    always @(posedge ref_clk) begin
        rd_data <= rfn(ptr);
        if (wr_valid === 1'b1) begin
            n_wr <= n_wr + 1;
            last_wr <= wr;
        end
        if (gc_reset === 1'b1) n_gc <= n_gc + 1;
        if (tmo === 1'b1) n_tmo <= n_tmo + 1;
    end
    task automatic chk(input string nm, input logic [15:0] got,
                       input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wb(input logic [7:0] d, output logic k);
        logic [7:0] q;
        m.xb(d, 1'b1, q, k);
    endtask
    initial begin
        #(30000 * 50);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        logic k;
        logic [7:0] q, p, d, e;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("ptr_rst", 16'(ptr), 16'h0000);
        rng = xs(rng);
        p = rng[7:0];
        d = rng[15:8];
        // own write: pointer then two data bytes back to back
        m.st();
        wb({ADDR_BASE + 7'(V), 1'b0}, k);
        chk("ack_addr", 16'(k), 16'h0000);
        wb(p, k);
        chk("ptr", 16'({k, ptr}), 16'(p));
        wb(d, k);
        chk("wr", 16'(last_wr), {p, d});
        wb(~d, k);
        chk("wr2", {n_wr[7:0], last_wr.data}, {8'h02, ~d});
        // repeated start into a read, pointer reused three times
        m.st();
        wb({ADDR_BASE + 7'(V), 1'b1}, k);
        chk("ack_rd", 16'(k), 16'h0000);
        for (int i = 0; i < 3; i++) begin
            m.xb(8'hFF, i == 2, q, k);
            chk("rd", 16'(q), 16'(rfn(p)));
        end
        m.sp();
        // foreign address is ignored with its data
        m.st();
        wb({3'b010, rng[19:16], 1'b0}, k);
        chk("nack_foreign", 16'(k), 16'h0001);
        wb(8'h3C, k);
        m.sp();
        chk("ptr_kept", {n_wr[7:0], ptr}, {8'h02, p});
        // broadcast write sets pointer and data
        p = {rng[23:18], 2'b00};
        m.st();
        wb(BC_WR_BYTE, k);
        chk("ack_bcw", 16'(k), 16'h0000);
        wb(p, k);
        chk("ack_bcp", 16'(k), 16'h0000);
        wb(d, k);
        m.sp();
        chk("bc_wr", 16'(last_wr), {p, d});
        // broadcast read over all slots, then with an early nack
        for (int n = 0; n < 2; n++) begin
            m.st();
            wb(BC_RD_BYTE, k);
            chk("ack_bcr", 16'(k), 16'h0000);
            for (int s = 0; s < 8; s++) begin
                m.xb(8'hFF, n == 1 && s == V - 1, q, k);
                e = (s == V && n == 0) ? rfn(p) : 8'hFF;
                chk("slot", 16'(q), 16'(e));
            end
            m.sp();
        end
        // hardware general call ignored, reset command honoured
        m.st();
        wb(BC_WR_BYTE, k);
        wb(8'h05, k);
        chk("hw_gc_nack", 16'(k), 16'h0001);
        m.st();
        wb(BC_WR_BYTE, k);
        wb(GC_RESET_CMD, k);
        chk("gc_ack", 16'(k), 16'h0000);
        m.sp();
        chk("gc", {n_gc[7:0], ptr}, 16'h0100);
        // master code, then high speed write until stop
        m.st();
        wb({5'h01, rng[26:24]}, k);
        chk("hs_nack", 16'({k, hs_mode}), 16'h0003);
        m.st();
        wb({ADDR_BASE + 7'(V), 1'b0}, k);
        wb(8'h04, k);
        chk("hs_wr", 16'({k, ptr}), 16'h0004);
        m.sp();
        chk("hs_off", 16'(hs_mode), 16'h0000);
        // scl held low while the own read address is acked
        e = {ADDR_BASE + 7'(V), 1'b1};
        m.st();
        for (int i = 7; i >= 0; i--)
            m.bt(e[i], k);
        m.tk(8);
        chk("tmo_ack", 16'({busy, sda}), 16'h0002);
        m.tk(TMO + 20);
        chk("tmo", {n_tmo[7:0], 6'h00, busy, sda}, 16'h0101);
        m.sp();
        tally_and_finish();
    end
endmodule
